// ### synth_ctrl_pkg.sv
package synth_ctrl_pkg;
  // ---------------------------------------------------------------
  // Word layout
  // ---------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam int COEF_W = 7;
  localparam int DIV_W = 12;
  localparam int REF_W = 5;
  localparam int COEF_HI_MSB = 5;
  localparam int TX_RX_SEL_POS = 6;
  localparam int NEW_POS = 7;
  localparam int PLL_POS = 8;
  localparam int SER_PWR_POS = 9;
  localparam int TEST_LO_LSB = 10;
  localparam int TEST_LO_MSB = 16;
  localparam int REF_SEL_LSB = 17;
  localparam int REF_SEL_MSB = 18;
  localparam int SLICER_FORCE_POS = 19;
  localparam int TEST_HI_LSB = 20;
  localparam int TEST_HI_MSB = 23;
  // ---------------------------------------------------------------
  // Reset values and ratios
  // ---------------------------------------------------------------
  localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
  localparam logic [DIV_W-1:0] MAIN_DIV_BASE = 12'h880;
  localparam logic [REF_W-1:0] REF_RATIO_00 = 5'h04;
  localparam logic [REF_W-1:0] REF_RATIO_01 = 5'h10;
  localparam logic [REF_W-1:0] REF_RATIO_10 = 5'h08;
  localparam logic [REF_W-1:0] REF_RATIO_11 = 5'h0C;
  localparam logic [1:0] SYNC_SETTLE = 2'h3;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_REDUCED,
    MODE_ADVANCED,
    MODE_ILLEGAL
  } op_mode_t;
endpackage

// ### word_link_if.sv
`timescale 1ns/100ps
interface word_link_if;
  logic [synth_ctrl_pkg::WORD_W-1:0] word;
  logic toggle;
  modport shifter (output word, output toggle);
  modport core (input word, input toggle);
endinterface

// ### serial_shifter.sv
`timescale 1ns/100ps
module serial_shifter (
  // Serial pins
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic loadEnN,
  // Word towards the core
  word_link_if.shifter link
);
  // Power-up values stand in for the reset that this side lacks
  logic [synth_ctrl_pkg::WORD_W-1:0] shift_r = synth_ctrl_pkg::WORD_RESET;
  logic [synth_ctrl_pkg::WORD_W-1:0] word_r = synth_ctrl_pkg::WORD_RESET;
  logic toggle_r = 1'b0;

  // ---------------------------------------------------------------
  // Shift on rising edge while enable is low
  // ---------------------------------------------------------------
  // No reset here: clock pulses outside frames come with enable high and are ignored
  always_ff @(posedge serialClk) begin
    if (!loadEnN) begin
      shift_r <= {shift_r[synth_ctrl_pkg::WORD_W-2:0],
                  serialData};
    end
  end

  // ---------------------------------------------------------------
  // Latch on enable rising edge
  // ---------------------------------------------------------------
  // Enable is the frame signal, so latching on its own edge needs no clock
  always_ff @(posedge loadEnN) begin
    word_r <= shift_r;
    toggle_r <= ~toggle_r;
  end

  assign link.word = word_r;
  assign link.toggle = toggle_r;

  property p_shift_in;
    @(posedge serialClk) !loadEnN |=> shift_r[0] == $past(serialData);
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("Data bit not shifted in");

  property p_hold;
    @(posedge serialClk) loadEnN && $past(loadEnN) |->
      $stable(shift_r);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Shifter moved while enable high");
endmodule

// ### synth_serial_control_word.sv
`timescale 1ns/100ps
// Functional notes
// - Coefficient is b5..b0 as upper bits, tx/rx select b6 as LSB
// - Main divider ratio equals 2176 plus the coefficient
// - Slicer force bit set turns internal slicer on via resistor
// - Slicer force bit clear routes demodulator straight to output pin
// - Slicer switch control high makes threshold node bypass resistor
// - Reference select 00/01/10/11 gives ratio 4/16/8/12
// - Mode from b9,b7: 00 normal, 01 reduced, 11 advanced; 10 banned
// - PLL hold bit keeps loop closed while VCO is on
// - Serial clock and data ignored until load enable goes low
// - Only last 24 bits kept; pulse count not checked
// - Word transferred to control logic when load enable rises
module synth_serial_control_word (
  // System
  input wire logic clk,
  input wire logic nrst,
  // Serial bus
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic loadEnN,
  // Analog switch controls
  input wire logic slicerSwitchCtrl,
  input wire logic vcoOn,
  // Decoded outputs
  output logic [synth_ctrl_pkg::DIV_W-1:0] mainDivRatio,
  output logic [synth_ctrl_pkg::REF_W-1:0] refDivRatio,
  output logic [1:0] opMode,
  output logic txRxSelect,
  output logic pllHold,
  output logic pllForceOn,
  output logic slicerOn,
  output logic demodDirect,
  output logic thresholdBypass,
  output logic testBitsSet
);
  word_link_if link();

  serial_shifter u_shifter (
    .serialClk(serialClk),
    .serialData(serialData),
    .loadEnN(loadEnN),
    .link(link)
  );

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rstMeta_r;
  logic rstSync_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end
  logic rstN;
  assign rstN = rstSync_r;

  // ---------------------------------------------------------------
  // Crossing: toggle through two flops, word sampled after it settles
  // ---------------------------------------------------------------
  logic togMeta_r;
  logic togSync_r;
  logic togSeen_r;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      togMeta_r <= 1'b0;
      togSync_r <= 1'b0;
      togSeen_r <= 1'b0;
    end else begin
      togMeta_r <= link.toggle;
      togSync_r <= togMeta_r;
      togSeen_r <= togSync_r;
    end
  end
  // Link side keeps its toggle over reset: wait for the seen copy
  logic [1:0] primed_r;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      primed_r <= 2'h0;
    end else if (primed_r != synth_ctrl_pkg::SYNC_SETTLE) begin
      primed_r <= primed_r + 2'h1;
    end
  end
  logic newWord;
  assign newWord = (primed_r == synth_ctrl_pkg::SYNC_SETTLE) &
                   (togSync_r ^ togSeen_r);

  // Word is stable for a whole frame after the toggle, so no sync needed
  logic [synth_ctrl_pkg::WORD_W-1:0] word_r;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      word_r <= synth_ctrl_pkg::WORD_RESET;
    end else if (newWord) begin
      word_r <= link.word;
    end
  end

  // ---------------------------------------------------------------
  // Pin level synchronisers
  // ---------------------------------------------------------------
  logic [1:0] pinMeta_r;
  logic [1:0] pinSync_r;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pinMeta_r <= 2'h0;
      pinSync_r <= 2'h0;
    end else begin
      pinMeta_r <= {vcoOn, slicerSwitchCtrl};
      pinSync_r <= pinMeta_r;
    end
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  function automatic logic [synth_ctrl_pkg::REF_W-1:0] refRatio(
    input logic [1:0] sel);
    case (sel)
      2'h0: refRatio = synth_ctrl_pkg::REF_RATIO_00;
      2'h1: refRatio = synth_ctrl_pkg::REF_RATIO_01;
      2'h2: refRatio = synth_ctrl_pkg::REF_RATIO_10;
      default: refRatio = synth_ctrl_pkg::REF_RATIO_11;
    endcase
  endfunction

  logic [synth_ctrl_pkg::COEF_W-1:0] coef;
  assign coef = {word_r[synth_ctrl_pkg::COEF_HI_MSB:0],
                 word_r[synth_ctrl_pkg::TX_RX_SEL_POS]};

  synth_ctrl_pkg::op_mode_t modeNxt;
  always_comb begin
    case ({word_r[synth_ctrl_pkg::SER_PWR_POS],
           word_r[synth_ctrl_pkg::NEW_POS]})
      2'h0: modeNxt = synth_ctrl_pkg::MODE_NORMAL;
      2'h1: modeNxt = synth_ctrl_pkg::MODE_REDUCED;
      2'h3: modeNxt = synth_ctrl_pkg::MODE_ADVANCED;
      default: modeNxt = synth_ctrl_pkg::MODE_ILLEGAL;
    endcase
  end

  logic testNxt;
  assign testNxt =
    (|word_r[synth_ctrl_pkg::TEST_HI_MSB:synth_ctrl_pkg::TEST_HI_LSB]) |
    (|word_r[synth_ctrl_pkg::TEST_LO_MSB:synth_ctrl_pkg::TEST_LO_LSB]);

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      mainDivRatio <= synth_ctrl_pkg::MAIN_DIV_BASE;
      refDivRatio <= synth_ctrl_pkg::REF_RATIO_00;
      opMode <= 2'h0;
      txRxSelect <= 1'b0;
      testBitsSet <= 1'b0;
    end else begin
      mainDivRatio <= synth_ctrl_pkg::MAIN_DIV_BASE +
                      {5'h00, coef};
      refDivRatio <= refRatio(word_r[synth_ctrl_pkg::REF_SEL_MSB:
                                     synth_ctrl_pkg::REF_SEL_LSB]);
      opMode <= modeNxt;
      txRxSelect <= word_r[synth_ctrl_pkg::TX_RX_SEL_POS];
      // Flags a controller that breaks the zero test-bit contract
      testBitsSet <= testNxt;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pllHold <= 1'b0;
      pllForceOn <= 1'b0;
    end else begin
      pllHold <= word_r[synth_ctrl_pkg::PLL_POS];
      pllForceOn <= word_r[synth_ctrl_pkg::PLL_POS] & pinSync_r[1];
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      slicerOn <= 1'b0;
      demodDirect <= 1'b1;
      thresholdBypass <= 1'b0;
    end else begin
      slicerOn <= word_r[synth_ctrl_pkg::SLICER_FORCE_POS];
      demodDirect <= !word_r[synth_ctrl_pkg::SLICER_FORCE_POS];
      thresholdBypass <= pinSync_r[0];
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_div;
    @(posedge clk) disable iff (!rstN)
      mainDivRatio == $past(synth_ctrl_pkg::MAIN_DIV_BASE + {5'h00, coef});
  endproperty
  a_div: assert property (p_div)
    else $error("Main divider ratio wrong");

  property p_div_range;
    @(posedge clk) disable iff (!rstN)
      mainDivRatio >= 12'h880 && mainDivRatio <= 12'h8FF;
  endproperty
  a_div_range: assert property (p_div_range)
    else $error("Main divider out of range");

  property p_ref;
    @(posedge clk) disable iff (!rstN)
      $past(word_r[18:17]) == 2'h1 |-> refDivRatio == 5'h10;
  endproperty
  a_ref: assert property (p_ref)
    else $error("Reference ratio decode wrong");

  property p_mode;
    @(posedge clk) disable iff (!rstN)
      $past(word_r[9]) && $past(word_r[7]) |-> opMode == 2'h2;
  endproperty
  a_mode: assert property (p_mode)
    else $error("Advanced mode not selected");

  property p_slicer;
    @(posedge clk) disable iff (!rstN) slicerOn != demodDirect;
  endproperty
  a_slicer: assert property (p_slicer)
    else $error("Slicer and direct path both set");

  property p_slicer_force_bit_on;
    @(posedge clk) disable iff (!rstN)
      $past(word_r[19]) |-> slicerOn;
  endproperty
  a_slicer_force_bit_on: assert property (p_slicer_force_bit_on)
    else $error("Slicer not forced on");

  property p_bypass;
    @(posedge clk) disable iff (!rstN)
      slicerSwitchCtrl [*4] |-> ##[1:3] thresholdBypass;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("Threshold bypass late");

  property p_pll;
    @(posedge clk) disable iff (!rstN) pllForceOn |-> pllHold;
  endproperty
  a_pll: assert property (p_pll)
    else $error("Loop forced without hold bit");

  property p_load;
    @(posedge clk) disable iff (!rstN)
      newWord |=> word_r == $past(link.word);
  endproperty
  a_load: assert property (p_load)
    else $error("Word not transferred");

  property p_ref_four;
    @(posedge clk) disable iff (!rstN)
      $past(word_r[18:17]) == 2'h0 |-> refDivRatio == 5'h04;
  endproperty
  a_ref_four: assert property (p_ref_four)
    else $error("Reference ratio four wrong");

  property p_ref_eight;
    @(posedge clk) disable iff (!rstN)
      $past(word_r[18:17]) == 2'h2 |-> refDivRatio == 5'h08;
  endproperty
  a_ref_eight: assert property (p_ref_eight)
    else $error("Reference ratio eight wrong");

  property p_ref_twelve;
    @(posedge clk) disable iff (!rstN)
      $past(word_r[18:17]) == 2'h3 |-> refDivRatio == 5'h0C;
  endproperty
  a_ref_twelve: assert property (p_ref_twelve)
    else $error("Reference ratio twelve wrong");

  property p_reduced;
    @(posedge clk) disable iff (!rstN)
      !$past(word_r[9]) && $past(word_r[7]) |-> opMode == 2'h1;
  endproperty
  a_reduced: assert property (p_reduced)
    else $error("Reduced mode not selected");

  property p_banned;
    @(posedge clk) disable iff (!rstN)
      $past(word_r[9]) && !$past(word_r[7]) |-> opMode == 2'h3;
  endproperty
  a_banned: assert property (p_banned)
    else $error("Forbidden mode not reported");

  property p_trx_lsb;
    @(posedge clk) disable iff (!rstN)
      mainDivRatio[0] == txRxSelect;
  endproperty
  a_trx_lsb: assert property (p_trx_lsb)
    else $error("Coefficient LSB is not the select bit");

  property p_bypass_off;
    @(posedge clk) disable iff (!rstN)
      (!slicerSwitchCtrl) [*4] |-> ##[1:3] !thresholdBypass;
  endproperty
  a_bypass_off: assert property (p_bypass_off)
    else $error("Threshold bypass stuck on");

  property p_test_flag;
    @(posedge clk) disable iff (!rstN)
      $past(|word_r[23:20]) |-> testBitsSet;
  endproperty
  a_test_flag: assert property (p_test_flag)
    else $error("Test bits not flagged");

  property p_force_on;
    @(posedge clk) disable iff (!rstN)
      $past(word_r[8]) && $past(pinSync_r[1]) |-> pllForceOn;
  endproperty
  a_force_on: assert property (p_force_on)
    else $error("Loop not held while oscillator on");
endmodule

// ### serial_master.sv
`timescale 1ns/100ps
module serial_master (
  // Serial pins
  output logic serialClk,
  output logic serialData,
  output logic loadEnN
);
  // ---------------------------------------------------------------
  // Link clock runs inside frames and in stray bursts, 6 ns period
  // ---------------------------------------------------------------
  localparam real HALF = 3.0;

  initial begin
    serialClk = 1'b0;
    serialData = 1'b0;
    loadEnN = 1'b1;
  end

  // Sends the low n bits of w, highest first; a 24-bit frame has its test bits cleared and b7 set wherever b9 is set
  task automatic send(input logic [31:0] w, input int n);
    logic [31:0] v;
    v = w;
    if (n == 24) begin
      v = v & ~32'h00F1FC00;
      v[7] = v[7] | v[9];
    end
    loadEnN = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serialData = v[i];
      #HALF serialClk = 1'b1;
      #HALF serialClk = 1'b0;
    end
    loadEnN = 1'b1;
    // Released line shows the inverse so a stale value cannot pass
    #HALF serialData = ~serialData;
  endtask

  // Clock pulses with the enable high; these must be ignored
  task automatic stray(input int n);
    serialData = 1'b1;
    repeat (n) begin
      #HALF serialClk = 1'b1;
      #HALF serialClk = 1'b0;
    end
  endtask
endmodule

// ### testbench.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  nTests++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); \
  end \
end
module testbench;
  // ---------------------------------------------------------------
  // Wiring
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic slicerSwitchCtrl = 1'b0;
  logic vcoOn = 1'b0;
  logic serialClk;
  logic serialData;
  logic loadEnN;
  logic [synth_ctrl_pkg::DIV_W-1:0] mainDivRatio;
  logic [synth_ctrl_pkg::REF_W-1:0] refDivRatio;
  logic [1:0] opMode;
  logic txRxSelect, pllHold, pllForceOn, slicerOn;
  logic demodDirect, thresholdBypass, testBitsSet;
  int errors = 0;
  int nTests = 0;
  typedef struct {
    logic [23:0] word;
    logic [11:0] div;
    logic [4:0] refr;
    logic [1:0] mode;
  } row_t;
  // Coefficient ends, all reference codes, all allowed modes
  row_t rows [4] = '{'{24'h000000, 12'h880, 5'h04, 2'h0},
                     '{24'h0200FF, 12'h8FF, 5'h10, 2'h1},
                     '{24'h0C03D7, 12'h8AF, 5'h08, 2'h2},
                     '{24'h060020, 12'h8C0, 5'h0C, 2'h0}};

  always #20 clk = ~clk;

  synth_serial_control_word dut_u (
    .clk(clk), .nrst(nrst), .serialClk(serialClk),
    .serialData(serialData), .loadEnN(loadEnN),
    .slicerSwitchCtrl(slicerSwitchCtrl), .vcoOn(vcoOn),
    .mainDivRatio(mainDivRatio), .refDivRatio(refDivRatio),
    .opMode(opMode), .txRxSelect(txRxSelect), .pllHold(pllHold),
    .pllForceOn(pllForceOn), .slicerOn(slicerOn),
    .demodDirect(demodDirect), .thresholdBypass(thresholdBypass),
    .testBitsSet(testBitsSet)
  );

  serial_master host_u (
    .serialClk(serialClk), .serialData(serialData), .loadEnN(loadEnN)
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check_word(input logic [23:0] w, input logic [11:0] div,
      input logic [4:0] refr, input logic [1:0] mode);
    `CHK(mainDivRatio, div)
    `CHK(refDivRatio, refr)
    `CHK(opMode, mode)
    `CHK(txRxSelect, w[6])
    `CHK(pllHold, w[8])
    `CHK(pllForceOn, w[8] & vcoOn)
    `CHK(slicerOn, w[19])
    `CHK(demodDirect, ~w[19])
    `CHK(thresholdBypass, slicerSwitchCtrl)
    `CHK(testBitsSet, 1'b0)
  endtask

  // Eight clk cycles cover the 3-4 cycle answer and frame spacing
  task automatic load(input logic [31:0] w, input int n);
    host_u.send(w, n);
    repeat (8) @(negedge clk);
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    check_word(24'h0, 12'h880, 5'h04, 2'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      slicerSwitchCtrl = i[0];
      vcoOn = i[1];
      load({8'h00, rows[i].word}, 24);
      check_word(rows[i].word, rows[i].div, rows[i].refr,
                 rows[i].mode);
      $display("test row %0d done", i);
    end
    // Leading junk bits must fall off the top
    load(32'hA50200FF, 32);
    check_word(24'h0200FF, 12'h8FF, 5'h10, 2'h1);
    $display("test long frame done");
    // Stray clocks with enable high, then a short frame
    load(32'h00000003, 24);
    host_u.stray(8);
    load(32'h00000080, 8);
    check_word(24'h000380, 12'h880, 5'h04, 2'h2);
    $display("test stray clocks done");
    // Second reset in mid-run clears the word
    slicerSwitchCtrl = 1'b0;
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    check_word(24'h0, 12'h880, 5'h04, 2'h0);
    nrst = 1'b1;
    // No stale word may come back once reset lets go
    repeat (8) @(negedge clk);
    check_word(24'h0, 12'h880, 5'h04, 2'h0);
    load({8'h00, rows[2].word}, 24);
    check_word(rows[2].word, rows[2].div, rows[2].refr,
               rows[2].mode);
    $display("test second reset done");
    // Forbidden mode and test bits sent raw to prove both flags
    load(32'h00F00200, 32);
    `CHK(opMode, 2'h3)
    `CHK(testBitsSet, 1'b1)
    `CHK(mainDivRatio, 12'h880)
    $display("test contract breach done");
    final_report();
  end

  // Nine frames of under 1 us each; a wide margin
  initial begin
    #100000;
    errors++;
    final_report();
  end
endmodule
